// file: rtl/lpddr2_params.svh
// constants for the low-power DDR2 command and power-state block
// assumes inclusion by bare name from every design file that needs it
`ifndef LPDDR2_PARAMS_SVH
`define LPDDR2_PARAMS_SVH

// ----------------------------------------------------------------------
// mode register space
// ----------------------------------------------------------------------
`define MRF_DEPTH          256
`define MR_ADDR_DEV_INFO   8'h00
`define MR_ADDR_FEATURE1   8'h01
`define MR_ADDR_MAKER      8'h05
`define MR_ADDR_REV1       8'h06
`define MR_ADDR_REV2       8'h07
`define MR_ADDR_CONFIG4    8'h08
`define MR_ADDR_CAL_A      8'h20
`define MR_ADDR_CAL_B      8'h28
`define MR1_RESET          8'h02

// ----------------------------------------------------------------------
// burst length codes held in the low bits of feature register 1
// ----------------------------------------------------------------------
`define BL_CODE_4          3'h2
`define BL_CODE_8          3'h3
`define BL_CODE_16         3'h4

// ----------------------------------------------------------------------
// burst engine and access queue
// ----------------------------------------------------------------------
`define PREFETCH_CYCLES    4'h2
`define ACC_FIFO_DEPTH     32

`endif

// file: rtl/lpddr2_pkg.sv
// types shared by the command and power-state block
// assumes nothing of its surroundings
package lpddr2_pkg;

    // --------------------------------------------------------------
    // power states of the die
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        PS_ACTIVE,
        PS_PD_PRE,
        PS_PD_ACT,
        PS_SREF,
        PS_DPD
    } pwr_state_t;

    // --------------------------------------------------------------
    // one queued read or write access
    // --------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       ap;
        logic [2:0] bank;
        logic [9:0] col;
    } access_t;

endpackage : lpddr2_pkg

// file: rtl/access_fifo.sv
// synchronous fifo between command decode and the burst engine
// assumes one clock; depth is a power of two
`timescale 1ns/10ps
module access_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr_ptr;
        logic [AW:0]                 rd_ptr;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t next_q;
    logic        full;
    logic        empty;

    // extra pointer bit tells full from empty without a counter
    assign full      = (q.wr_ptr[AW] != q.rd_ptr[AW]) && (q.wr_ptr[AW-1:0] == q.rd_ptr[AW-1:0]);
    assign empty     = (q.wr_ptr == q.rd_ptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = q.mem[q.rd_ptr[AW-1:0]];

    always_comb begin
        next_q = q;
        if (in_valid && !full) begin
            next_q.mem[q.wr_ptr[AW-1:0]] = in_data;
            next_q.wr_ptr = q.wr_ptr + (AW+1)'(1);
        end
        if (out_ready && !empty) begin
            next_q.rd_ptr = q.rd_ptr + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule : access_fifo

// file: rtl/mode_reg_file.sv
// mode register file: 256 byte-wide registers with per-address access type
// assumes write and read strobes are one-cycle pulses on the same clock
`timescale 1ns/10ps
`include "lpddr2_params.svh"
module mode_reg_file #(
    parameter logic [7:0] MAKER_CODE = 8'h5a,  // arbitrary value
    parameter logic [7:0] REV1_CODE  = 8'h01,  // arbitrary value
    parameter logic [7:0] REV2_CODE  = 8'h02   // arbitrary value
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_en,
    input  wire logic [7:0] rd_addr,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    output logic      [7:0] mr1
);
    typedef struct packed {
        logic [`MRF_DEPTH-1:0][7:0] mem;
        logic [7:0]                 rd_data;
        logic                       rd_valid;
    } mrf_state_t;

    mrf_state_t q;
    mrf_state_t next_q;

    function automatic logic readable(input logic [7:0] a);
        readable = (a == `MR_ADDR_DEV_INFO) || (a == `MR_ADDR_MAKER) || (a == `MR_ADDR_REV1) ||
                   (a == `MR_ADDR_REV2) || (a == `MR_ADDR_CONFIG4) || (a == `MR_ADDR_CAL_A) ||
                   (a == `MR_ADDR_CAL_B);
    endfunction : readable

    assign rd_data  = q.rd_data;
    assign rd_valid = q.rd_valid;
    assign mr1      = q.mem[`MR_ADDR_FEATURE1];

    always_comb begin
        next_q = q;
        next_q.rd_valid = 1'b0;
        if (wr_en && !readable(wr_addr)) begin
            next_q.mem[wr_addr] = wr_data;
        end
        if (rd_en) begin
            next_q.rd_valid = 1'b1;
            next_q.rd_data  = readable(rd_addr) ? q.mem[rd_addr] : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.mem[`MR_ADDR_FEATURE1] <= `MR1_RESET;
            q.mem[`MR_ADDR_MAKER]    <= MAKER_CODE;
            q.mem[`MR_ADDR_REV1]     <= REV1_CODE;
            q.mem[`MR_ADDR_REV2]     <= REV2_CODE;
        end else begin
            q <= next_q;
        end
    end
endmodule : mode_reg_file

// file: rtl/lpddr2_cmd_power.sv
// command decode, bank tracking, burst engine and power states of the die
// assumes the command pins come from another domain and are synchronised here;
// the rising and falling halves of the command/address bus arrive as two buses
//
// Summary of operation
// - 256 byte registers, read-only or write-only access
// - self-refresh command with falling CKE enters if no bank is open
// - activate decoded from two bits only
// - read/write from three bits, RFU ignored
// - auto-precharge taken from falling bit 0
// - precharge all when AB set, else one
// - burst terminate cuts at prefetch boundary
// - power-down disables buffers, watches CKE
// - power-down class follows open banks
// - deep power-down drops array, contents lost
// - only rising CKE leaves low-power states
// - deselect or NOP does nothing
// - CKE low twice keeps current state
// - falling CKE picks power-down, self-refresh or deep power-down
// - bursts of four, eight, sixteen, wrapped
// - activate then access, bank and row
// - chip select and CKE on rising edge
// - auto-precharge closes bank after burst
`timescale 1ns/10ps
`include "lpddr2_params.svh"
module lpddr2_cmd_power (
    input  wire logic                    SYS_CLK,
    input  wire logic                    RST_N,
    input  wire logic                    CKE,
    input  wire logic                    CS_N,
    input  wire logic [9:0]              CA_RISE,
    input  wire logic [9:0]              CA_FALL,
    output lpddr2_pkg::pwr_state_t       POWER_STATE,
    output logic                         INPUT_BUF_EN,
    output logic                         ARRAY_POWER_EN,
    output logic                         CLK_STOP_OK,
    output logic                         CONTENTS_LOST,
    output logic [7:0]                   BANK_OPEN,
    output logic                         ACT_PULSE,
    output logic [2:0]                   ACT_BANK,
    output logic [13:0]                  ACT_ROW,
    output logic                         REFRESH_PULSE,
    output logic                         REFRESH_ALL,
    output logic [7:0]                   MRR_DATA,
    output logic                         MRR_VALID,
    output logic                         BURST_ACTIVE,
    output logic                         BURST_WRITE,
    output logic [2:0]                   BURST_BANK,
    output logic [9:0]                   BURST_COL,
    output logic                         FIFO_READY,
    output logic                         ACCESS_DROP
);
    import lpddr2_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       cke_s1;
        logic       cke_s2;
        logic       cs_s1;
        logic       cs_s2;
        logic [9:0] car_s1;
        logic [9:0] car_s2;
        logic [9:0] caf_s1;
        logic [9:0] caf_s2;
        logic       cke_prev;
        pwr_state_t pstate;
        logic [7:0] bank_open;
        logic       busy;
        logic       b_wr;
        logic       b_ap;
        logic       b_stop;
        logic [2:0] b_bank;
        logic [9:0] b_base;
        logic [3:0] b_beat;
        logic       in_buf;
        logic       arr_pwr;
        logic       clk_ok;
        logic       lost;
        logic       act;
        logic [2:0] act_bank;
        logic [13:0] act_row;
        logic       ref_p;
        logic       ref_all;
        logic [7:0] mrr_data;
        logic       mrr_valid;
        logic [9:0] b_col;
        logic       fifo_rdy;
        logic       drop;
    } main_state_t;

    main_state_t q;
    main_state_t next_q;

    // decode strobes toward the mode register file and the queue
    logic        mrw_en;
    logic        mrr_en;
    logic [7:0]  mr_addr;
    logic [7:0]  mr1;
    logic [7:0]  mrf_data;
    logic        mrf_valid;
    logic        push;
    access_t     push_data;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    access_t     fifo_out_data;
    logic        pop;

    logic        cke_n;
    logic        cke_p;
    logic        c0;
    logic        c1;
    logic        c2;
    logic        c3;
    logic        nop_cmd;
    logic [3:0]  beats;
    logic [9:0]  wrap_mask;
    logic        last_beat;
    logic [3:0]  beat_nx;

    assign cke_n   = q.cke_s2;
    assign cke_p   = q.cke_prev;
    assign c0      = q.car_s2[0];
    assign c1      = q.car_s2[1];
    assign c2      = q.car_s2[2];
    assign c3      = q.car_s2[3];
    assign nop_cmd = q.cs_s2 || (c0 && c1 && c2);
    assign mr_addr = {q.caf_s2[1:0], q.car_s2[9:4]};

    // ------------------------------------------------------------------
    // burst length from feature register 1
    // ------------------------------------------------------------------
    // programmed length four, eight, sixteen
    always_comb begin
        case (mr1[2:0])
            `BL_CODE_8: begin
                beats     = 4'h4;
                wrap_mask = 10'h007;
            end
            `BL_CODE_16: begin
                beats     = 4'h8;
                wrap_mask = 10'h00f;
            end
            default: begin
                beats     = 4'h2;
                wrap_mask = 10'h003;
            end
        endcase
    end

    // two columns per clock; a prefetch boundary every two clocks
    assign beat_nx   = 4'(q.b_beat + 4'h1);
    // stop only on a prefetch boundary
    assign last_beat = (beat_nx == beats) ||
                       (q.b_stop && (beat_nx[0] == 1'b0) && (beat_nx >= `PREFETCH_CYCLES));
    assign pop       = !q.busy;

    always_comb begin
        next_q = q;
        // pins pass two flops before use
        next_q.cke_s1   = CKE;
        next_q.cke_s2   = q.cke_s1;
        next_q.cs_s1    = CS_N;
        next_q.cs_s2    = q.cs_s1;
        next_q.car_s1   = CA_RISE;
        next_q.car_s2   = q.car_s1;
        next_q.caf_s1   = CA_FALL;
        next_q.caf_s2   = q.caf_s1;
        next_q.cke_prev = cke_n;
        next_q.lost     = 1'b0;
        next_q.act      = 1'b0;
        next_q.ref_p    = 1'b0;
        next_q.drop     = 1'b0;
        next_q.mrr_data  = mrf_valid ? mrf_data : q.mrr_data;
        next_q.mrr_valid = mrf_valid;
        next_q.fifo_rdy  = fifo_in_ready;
        mrw_en    = 1'b0;
        mrr_en    = 1'b0;
        push      = 1'b0;
        push_data = '0;

        // --------------------------------------------------------------
        // burst engine
        // --------------------------------------------------------------
        if (q.busy) begin
            next_q.b_beat = beat_nx;
            if (last_beat) begin
                next_q.busy   = 1'b0;
                next_q.b_stop = 1'b0;
                if (q.b_ap) begin
                    next_q.bank_open[q.b_bank] = 1'b0;
                end
            end
        end else if (fifo_out_valid) begin
            next_q.busy   = 1'b1;
            next_q.b_wr   = fifo_out_data.wr;
            next_q.b_ap   = fifo_out_data.ap;
            next_q.b_bank = fifo_out_data.bank;
            next_q.b_base = fifo_out_data.col;
            next_q.b_beat = 4'h0;
            next_q.b_stop = 1'b0;
        end
        next_q.b_col = (next_q.b_base & ~wrap_mask) |
                       (10'(next_q.b_base + {5'h00, next_q.b_beat, 1'b0}) & wrap_mask);

        // --------------------------------------------------------------
        // power states and command decode
        // --------------------------------------------------------------
        case (q.pstate)
            PS_ACTIVE: begin
                if (cke_p && !cke_n) begin
                    // falling CKE chooses the low-power state
                    if (!q.cs_s2 && !c0 && !c1 && c2 && c3 && (q.bank_open == 8'h00)) begin
                        next_q.pstate = PS_SREF;
                    end else if (!q.cs_s2 && c0 && c1 && !c2) begin
                        next_q.pstate    = PS_DPD;
                        next_q.bank_open = 8'h00;
                        next_q.lost      = 1'b1;
                    end else begin
                        next_q.pstate = (q.bank_open == 8'h00) ? PS_PD_PRE : PS_PD_ACT;
                    end
                end else if (cke_p && cke_n && !nop_cmd) begin
                    if (!c0 && !c1 && !c2 && !c3) begin
                        mrw_en = 1'b1;
                    end else if (!c0 && !c1 && !c2 && c3) begin
                        mrr_en = 1'b1;
                    end else if (!c0 && !c1 && c2) begin
                        next_q.ref_p   = 1'b1;
                        next_q.ref_all = c3;
                    end else if (!c0 && c1) begin
                        // activate uses CA0 and CA1 only
                        next_q.act      = 1'b1;
                        next_q.act_bank = q.car_s2[9:7];
                        next_q.act_row  = {q.caf_s2[8], q.car_s2[6:2], q.caf_s2[7:0]};
                        next_q.bank_open[q.car_s2[9:7]] = 1'b1;
                    end else if (c0 && !c1) begin
                        push           = 1'b1;
                        push_data.wr   = !c2;
                        push_data.ap   = q.caf_s2[0];
                        push_data.bank = q.car_s2[9:7];
                        push_data.col  = {q.caf_s2[7:1], q.car_s2[6:5], 1'b0};
                        // a full queue loses the access; the flag tells the host
                        next_q.drop    = !fifo_in_ready;
                    end else if (c0 && c1 && !c2 && c3) begin
                        if (q.car_s2[4]) begin
                            next_q.bank_open = 8'h00;
                        end else begin
                            next_q.bank_open[q.car_s2[9:7]] = 1'b0;
                        end
                    end else begin
                        if (next_q.busy && !next_q.b_ap) begin
                            next_q.b_stop = 1'b1;
                        end
                    end
                end
            end
            PS_PD_PRE, PS_PD_ACT, PS_SREF, PS_DPD: begin
                // CKE low twice holds the state
                if (!cke_p && cke_n) begin
                    next_q.pstate = PS_ACTIVE;
                end
            end
            default: begin
                next_q.pstate = PS_ACTIVE;
            end
        endcase

        next_q.in_buf  = (next_q.pstate == PS_ACTIVE);
        next_q.arr_pwr = (next_q.pstate != PS_DPD);
        next_q.clk_ok  = (next_q.pstate == PS_PD_PRE) || (next_q.pstate == PS_PD_ACT);
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q         <= '0;
            q.in_buf  <= 1'b1;
            q.arr_pwr <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------------
    // leaves
    // ------------------------------------------------------------------
    // mode register read and write
    mode_reg_file u_mrf (
        .clk      (SYS_CLK),
        .rst_n    (RST_N),
        .wr_en    (mrw_en),
        .wr_addr  (mr_addr),
        .wr_data  (q.caf_s2[9:2]),
        .rd_en    (mrr_en),
        .rd_addr  (mr_addr),
        .rd_data  (mrf_data),
        .rd_valid (mrf_valid),
        .mr1      (mr1)
    );

    access_fifo #(
        .WIDTH ($bits(access_t)),
        .DEPTH (`ACC_FIFO_DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst_n     (RST_N),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data)
    );

    assign POWER_STATE    = q.pstate;
    assign INPUT_BUF_EN   = q.in_buf;
    assign ARRAY_POWER_EN = q.arr_pwr;
    assign CLK_STOP_OK    = q.clk_ok;
    assign CONTENTS_LOST  = q.lost;
    assign BANK_OPEN      = q.bank_open;
    assign ACT_PULSE      = q.act;
    assign ACT_BANK       = q.act_bank;
    assign ACT_ROW        = q.act_row;
    assign REFRESH_PULSE  = q.ref_p;
    assign REFRESH_ALL    = q.ref_all;
    assign MRR_DATA       = q.mrr_data;
    assign MRR_VALID      = q.mrr_valid;
    assign BURST_ACTIVE   = q.busy;
    assign BURST_WRITE    = q.b_wr;
    assign BURST_BANK     = q.b_bank;
    assign BURST_COL      = q.b_col;
    assign FIFO_READY     = q.fifo_rdy;
    assign ACCESS_DROP    = q.drop;
endmodule : lpddr2_cmd_power

// file: tb/lpddr2_cmd_power_properties.sv
// port assertions for the command and power-state block
// assumes the three-edge pin latency of the input synchronisers
`timescale 1ns/10ps
module lpddr2_cmd_power_properties (
    input wire logic                   SYS_CLK,
    input wire logic                   RST_N,
    input wire logic                   CKE,
    input wire logic                   CS_N,
    input wire logic [9:0]             CA_RISE,
    input wire lpddr2_pkg::pwr_state_t POWER_STATE,
    input wire logic                   INPUT_BUF_EN,
    input wire logic                   ARRAY_POWER_EN,
    input wire logic [7:0]             BANK_OPEN,
    input wire logic                   ACT_PULSE,
    input wire logic [2:0]             ACT_BANK,
    input wire logic                   REFRESH_PULSE
);
    import lpddr2_pkg::*;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    property p_buf; INPUT_BUF_EN == (POWER_STATE == PS_ACTIVE); endproperty
    a_buf: assert property (p_buf) else $error("buffers on outside active");
    property p_arr; ARRAY_POWER_EN == (POWER_STATE != PS_DPD); endproperty
    a_arr: assert property (p_arr) else $error("array power wrong");
    property p_exit; ($past(POWER_STATE) != PS_ACTIVE && POWER_STATE == PS_ACTIVE)
        |-> $past(CKE, 3) && !$past(CKE, 4); endproperty
    a_exit: assert property (p_exit) else $error("exit without rising cke");
    property p_keep; (POWER_STATE != PS_ACTIVE && !$past(CKE, 2) && !$past(CKE, 3))
        |=> POWER_STATE == $past(POWER_STATE); endproperty
    a_keep: assert property (p_keep) else $error("state left with cke low");
    property p_act; ACT_PULSE |-> !$past(CS_N, 3) && ($past(CA_RISE, 3) & 10'h003) == 10'h002
        && BANK_OPEN[ACT_BANK]; endproperty
    a_act: assert property (p_act) else $error("activate badly decoded");
    property p_nop; $past(CS_N, 3) |-> !ACT_PULSE && !REFRESH_PULSE; endproperty
    a_nop: assert property (p_nop) else $error("deselect did something");
    property p_sref; ($past(POWER_STATE) == PS_ACTIVE && POWER_STATE == PS_SREF) |-> !$past(CS_N, 3)
        && !$past(CKE, 3) && $past(CKE, 4) && ($past(CA_RISE, 3) & 10'h00f) == 10'h00c; endproperty
    a_sref: assert property (p_sref) else $error("bad self-refresh entry");
    property p_ign; POWER_STATE != PS_ACTIVE |-> !ACT_PULSE && !REFRESH_PULSE; endproperty
    a_ign: assert property (p_ign) else $error("command taken in low power");
endmodule : lpddr2_cmd_power_properties

bind lpddr2_cmd_power lpddr2_cmd_power_properties lpddr2_cmd_power_properties_i (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CKE(CKE), .CS_N(CS_N), .CA_RISE(CA_RISE),
    .POWER_STATE(POWER_STATE), .INPUT_BUF_EN(INPUT_BUF_EN), .ARRAY_POWER_EN(ARRAY_POWER_EN),
    .BANK_OPEN(BANK_OPEN), .ACT_PULSE(ACT_PULSE), .ACT_BANK(ACT_BANK), .REFRESH_PULSE(REFRESH_PULSE)
);

// file: tb/lpddr2_ctrl_model.sv
// memory controller model driving the command pins
// assumes its tasks are entered just after a rising edge
`timescale 1ns/10ps
module lpddr2_ctrl_model (
    input  wire logic       clk,
    output logic            cke,
    output logic            cs_n,
    output logic [9:0]      ca_rise,
    output logic [9:0]      ca_fall
);
    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        ca_rise = 10'h000;
        ca_fall = 10'h000;
    end
    task automatic cmd(input logic cs, input logic [9:0] r, input logic [9:0] f, input logic ke);
        cke = ke;
        cs_n = cs;
        ca_rise = r;
        ca_fall = f;
        @(posedge clk);
        #1;
    endtask : cmd
    // released bus shows the inverse, not a stale value
    task automatic nop();
        cs_n = 1'b1;
        ca_rise = ~ca_rise;
        ca_fall = ~ca_fall;
        @(posedge clk);
        #1;
    endtask : nop
endmodule : lpddr2_ctrl_model

// file: tb/test_lpddr2_cmd_power.sv
// self-checking bench for the command and power-state block
// assumes the controller model drives every command pin
`timescale 1ns/10ps
`include "lpddr2_params.svh"
module test_lpddr2_cmd_power;
    import lpddr2_pkg::*;
    logic        sys_clk, rst_n, in_buf, arr, stop, lost, actp, refp, refa, mrv, bact, bwr, frdy, drop, full;
    wire logic   cke, cs_n;
    wire logic [9:0] car, caf;
    pwr_state_t  ps;
    logic [7:0]  bo, mrd;
    logic [2:0]  abank, bbank;
    logic [13:0] arow;
    logic [9:0]  bcol;
    int          num_errors, checked, cyc, n, d;
    logic        pcs [3] = '{1'b1, 1'b0, 1'b0};
    logic [9:0]  pca [3] = '{10'h000, 10'h00c, 10'h003};
    pwr_state_t  pst [3] = '{PS_PD_PRE, PS_SREF, PS_DPD};
    logic [2:0]  blc [3] = '{`BL_CODE_16, `BL_CODE_8, `BL_CODE_4};
    int          bln [3] = '{8, 4, 2};

    lpddr2_ctrl_model lpddr2_ctrl_model_i (.clk(sys_clk), .cke(cke), .cs_n(cs_n), .ca_rise(car), .ca_fall(caf));
    lpddr2_cmd_power lpddr2_cmd_power_i (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .CKE(cke), .CS_N(cs_n), .CA_RISE(car), .CA_FALL(caf),
        .POWER_STATE(ps), .INPUT_BUF_EN(in_buf), .ARRAY_POWER_EN(arr), .CLK_STOP_OK(stop),
        .CONTENTS_LOST(lost), .BANK_OPEN(bo), .ACT_PULSE(actp), .ACT_BANK(abank), .ACT_ROW(arow),
        .REFRESH_PULSE(refp), .REFRESH_ALL(refa), .MRR_DATA(mrd), .MRR_VALID(mrv), .BURST_ACTIVE(bact),
        .BURST_WRITE(bwr), .BURST_BANK(bbank), .BURST_COL(bcol), .FIFO_READY(frdy), .ACCESS_DROP(drop));

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : step
    // one command, a deselect, then wait k edges for the answer
    task automatic run(input logic cs, input logic [9:0] r, input logic [9:0] f, input logic ke, input int k);
        lpddr2_ctrl_model_i.cmd(cs, r, f, ke);
        lpddr2_ctrl_model_i.nop();
        step(k);
    endtask : run
    task automatic burst_len();
        n = 0;
        while (bact === 1'b1 && n < 40) begin
            n++;
            step(1);
        end
    endtask : burst_len
    task automatic test_done();
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        cmp({ps, in_buf, arr, bo}, {PS_ACTIVE, 2'b11, 8'h00});
        rst_n = 1'b1;
        // the previous-CKE flop needs one edge after release before a command counts
        step(1);
        run(1'b0, 10'h1aa, 10'h15c, 1'b1, 1);
        cmp({actp, abank, arow, bo}, {1'b1, 3'h3, 14'h2a5c, 8'h08});
        run(1'b0, 10'h1bd, 10'h013, 1'b1, 2);
        cmp({bact, bwr, bbank, bcol}, {2'b10, 3'h3, 10'h04a});
        step(1);
        cmp(bcol, 10'h048);
        step(1);
        cmp({bact, bo}, 9'h000);
        run(1'b0, 10'h100, 10'h294, 1'b1, 1);
        run(1'b0, 10'h108, 10'h000, 1'b1, 2);
        cmp({mrv, mrd}, 9'h100);
        run(1'b0, 10'h050, 10'h0cc, 1'b1, 1);
        run(1'b0, 10'h058, 10'h000, 1'b1, 2);
        cmp({mrv, mrd}, 9'h15a);
        run(1'b0, 10'h002, 10'h000, 1'b1, 1);
        run(1'b0, 10'h010, {5'h00, `BL_CODE_16, 2'b00}, 1'b1, 1);
        lpddr2_ctrl_model_i.cmd(1'b0, 10'h001, 10'h000, 1'b1);
        run(1'b0, 10'h003, 10'h000, 1'b1, 1);
        cmp({bact, bwr}, 2'b11);
        burst_len();
        cmp({n < 8, n[0]}, 2'b10);
        foreach (bln[i]) begin
            run(1'b0, 10'h010, {5'h00, blc[i], 2'b00}, 1'b1, 1);
            run(1'b0, 10'h005, 10'h000, 1'b1, 2);
            burst_len();
            cmp(n, bln[i]);
        end
        // back-to-back reads outrun the burst engine until the queue refuses
        full = 1'b0;
        d = 0;
        for (int i = 0; i < 70; i++) begin
            lpddr2_ctrl_model_i.cmd(1'b0, 10'h005, 10'h000, 1'b1);
            full |= (frdy === 1'b0);
            d += (drop === 1'b1);
        end
        lpddr2_ctrl_model_i.nop();
        cmp({full, d > 0}, 2'b11);
        n = 0;
        d = 0;
        while (d < 4 && n < 400) begin
            d = (bact === 1'b1) ? 0 : d + 1;
            n++;
            step(1);
        end
        cmp({bact, frdy}, 2'b01);
        run(1'b0, 10'h082, 10'h000, 1'b1, 1);
        run(1'b0, 10'h102, 10'h000, 1'b1, 2);
        run(1'b0, 10'h08b, 10'h000, 1'b1, 2);
        cmp(bo, 8'h05);
        run(1'b1, 10'h000, 10'h000, 1'b0, 2);
        cmp({ps, in_buf, stop}, {PS_PD_ACT, 2'b01});
        run(1'b0, 10'h302, 10'h000, 1'b0, 2);
        cmp({ps, bo}, {PS_PD_ACT, 8'h05});
        run(1'b1, 10'h000, 10'h000, 1'b1, 2);
        cmp(ps, PS_ACTIVE);
        run(1'b0, 10'h29b, 10'h000, 1'b1, 2);
        cmp(bo, 8'h00);
        run(1'b0, 10'h00c, 10'h000, 1'b1, 1);
        cmp({refp, refa, ps}, {2'b11, PS_ACTIVE});
        run(1'b0, 10'h004, 10'h000, 1'b1, 1);
        cmp({refp, refa}, 2'b10);
        // banks idle from here, so self-refresh may be asked for
        foreach (pcs[i]) begin
            run(pcs[i], pca[i], 10'h000, 1'b0, 1);
            cmp({ps, in_buf, arr, stop, lost},
                {pst[i], 1'b0, pst[i] != PS_DPD, pst[i] == PS_PD_PRE, pst[i] == PS_DPD});
            run(1'b1, 10'h000, 10'h000, 1'b1, 2);
            cmp({ps, arr}, {PS_ACTIVE, 1'b1});
        end
        test_done();
    end
endmodule : test_lpddr2_cmd_power
